// file: logic/acc_aux_converter_control.sv
// aux ADC / aux DAC control logic behind the serial control registers
// Function
// - start-average bit is a self-clearing trigger
// - 3-bit code selects 1 to 64 samples
// - average lands in that ADC's result registers
// - aux chip-select pin may trigger averaging
// - latest result held read-only, 10-bit
// - result split: upper eight, lower two bits
// - aux port works only when enabled
// - port-select low means A, high B
// - reference select: low external, high internal
// - input select: low second, high first
// - start bits begin single conversion, read zero
// - 2-bit code picks aux ADC clock
// - 8-bit DAC words apply at write end
// - DAC words reset to zero
// - slave mode holds DAC outputs until update
// - update bits apply pending words, read zero
// - DAC powered only while power bit set
// - fullscale bit: low 3.0 V, high 2.5 V
// - separate DAC fullscale fields, bits 7-2
`timescale 1ns/1ps
`include "acc_params.svh"

module acc_aux_converter_control (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_srst,
   // decoded serial control port access
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // aux serial port chip select pin
   input wire logic i_aux_cs_n,
   // aux ADC A
   output logic o_adc_a_convert,
   input wire logic i_adc_a_done,
   input wire logic [9:0] i_adc_a_data,
   output logic o_adc_a_input_select,
   output logic o_adc_a_ref_internal,
   // aux ADC B
   output logic o_adc_b_convert,
   input wire logic i_adc_b_done,
   input wire logic [9:0] i_adc_b_data,
   output logic o_adc_b_ref_internal,
   // shared aux ADC settings
   output logic [1:0] o_aux_adc_clock_selection,
   output logic o_ref_generator_enable,
   output logic o_internal_reference_fullscale,
   output logic o_aux_port_enable,
   output logic o_aux_port_target_select,
   // aux DACs
   output logic [7:0] o_dac_a_level,
   output logic [7:0] o_dac_b_level,
   output logic [7:0] o_dac_c_level,
   output logic [2:0] o_dac_power_up,
   output logic [5:0] o_dac_fullscale
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   acc_pkg::acc_state_t s;
   acc_pkg::acc_state_t next_s;
   logic [1:0][9:0] adc_data;
   logic [1:0] adc_done;
   logic cs_fall;

   // channel 0 is ADC A, channel 1 is ADC B
   assign adc_data = {i_adc_b_data, i_adc_a_data};
   assign adc_done = {i_adc_b_done, i_adc_a_done};
   // falling chip select, taken from synchronised stages only
   assign cs_fall = s.cs_q3 & ~s.cs_q2;

   // ----------------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      logic [7:0] roff;
      logic trig_avg;
      logic trig_pin;
      logic trig_single;
      logic [2:0] code;
      logic [15:0] sum;
      logic [1:0] ridx;
      logic [7:0] wsel;
      next_s = s;
      roff = 8'h00;
      trig_avg = 1'b0;
      trig_pin = 1'b0;
      trig_single = 1'b0;
      code = `ACC_CODE_SINGLE;
      sum = 16'h0000;
      ridx = `ACC_RES_IDX_A2;
      wsel = 8'h00;
      next_s.convert = 2'b00;
      next_s.rvalid = 1'b0;
      // two-stage synchroniser on the pin, third stage for edge detect
      next_s.cs_q1 = i_aux_cs_n;
      next_s.cs_q2 = s.cs_q1;
      next_s.cs_q3 = s.cs_q2;

      // register writes
      if (i_reg_wr) begin
         unique case (i_reg_addr)
            `ACC_ADDR_FS: begin
               next_s.dac_fs = i_reg_wdata[7:2];
               next_s.ref_en = i_reg_wdata[`ACC_BIT_REF_EN];
               next_s.ref_fs = i_reg_wdata[`ACC_BIT_REF_FS];
            end
            `ACC_ADDR_AVG_A, `ACC_ADDR_AVG_B: begin
               // unused code 111 is stored as the 64-sample code
               code = (i_reg_wdata[2:0] == `ACC_CODE_UNUSED) ?
                      `ACC_CODE_MAX : i_reg_wdata[2:0];
               next_s.avg_code[i_reg_addr[0]] = code;
            end
            `ACC_ADDR_ADC_CTRL: begin
               next_s.port_en = i_reg_wdata[`ACC_BIT_PORT_EN];
               next_s.port_sel = i_reg_wdata[`ACC_BIT_PORT_SEL];
               next_s.ref_sel[1] = i_reg_wdata[`ACC_BIT_REFSEL_B];
               next_s.ref_sel[0] = i_reg_wdata[`ACC_BIT_REFSEL_A];
               next_s.input_sel = i_reg_wdata[`ACC_BIT_INSEL_A];
            end
            `ACC_ADDR_CLK_DIV: begin
               next_s.clk_sel = i_reg_wdata[1:0];
            end
            `ACC_ADDR_DAC_A, `ACC_ADDR_DAC_B, `ACC_ADDR_DAC_C: begin
               wsel = i_reg_addr - `ACC_ADDR_DAC_A;
               next_s.dac_pend[wsel[1:0]] = i_reg_wdata;
               // outside slave mode the word drives the DAC at once
               if (!s.slave_en) begin
                  next_s.dac_live[wsel[1:0]] = i_reg_wdata;
               end
            end
            `ACC_ADDR_DAC_UPD: begin
               next_s.slave_en = i_reg_wdata[`ACC_BIT_SLAVE_EN];
               // update bits are not stored, so they always read low
               for (int d = 0; d < 3; d++) begin
                  if (i_reg_wdata[`ACC_BIT_SLAVE_EN] && i_reg_wdata[d]) begin
                     next_s.dac_live[d] = s.dac_pend[d];
                  end
               end
            end
            `ACC_ADDR_DAC_PWR: begin
               next_s.dac_pwr = i_reg_wdata[2:0];
            end
            default: begin
               // read-only or unmapped: write ignored
            end
         endcase
      end

      // conversion sequencers, one per aux ADC
      for (int c = 0; c < 2; c++) begin
         trig_avg = i_reg_wr && i_reg_wdata[`ACC_BIT_START_AVG] &&
                    (i_reg_addr == (c == 0 ? `ACC_ADDR_AVG_A :
                                             `ACC_ADDR_AVG_B));
         trig_pin = cs_fall && s.port_en &&
                    (s.port_sel == c[0]);
         trig_single = i_reg_wr && (i_reg_addr == `ACC_ADDR_ADC_CTRL) &&
                       i_reg_wdata[c == 0 ? `ACC_BIT_START_A :
                                            `ACC_BIT_START_B];
         unique case (s.st[c])
            acc_pkg::ACC_IDLE: begin
               // a trigger while busy is dropped, never queued
               if (trig_avg || trig_pin || trig_single) begin
                  if (trig_avg || trig_pin) begin
                     code = next_s.avg_code[c];
                  end else begin
                     code = `ACC_CODE_SINGLE;
                  end
                  next_s.left[c] = `ACC_LEFT_ONE << code;
                  next_s.shift[c] = code;
                  next_s.acc[c] = 16'h0000;
                  next_s.convert[c] = 1'b1;
                  next_s.st[c] = acc_pkg::ACC_SAMPLE;
                  if (c == 0) begin
                     next_s.a_src = next_s.input_sel;
                  end
               end
            end
            acc_pkg::ACC_SAMPLE: begin
               if (adc_done[c]) begin
                  sum = s.acc[c] + {6'h00, adc_data[c]};
                  if (s.left[c] == `ACC_LEFT_ONE) begin
                     if (c == 1) begin
                        ridx = `ACC_RES_IDX_B;
                     end else if (s.a_src) begin
                        ridx = `ACC_RES_IDX_A1;
                     end else begin
                        ridx = `ACC_RES_IDX_A2;
                     end
                     // sum of 2^n samples shifted by n keeps 10 bits
                     sum = sum >> s.shift[c];
                     next_s.result[ridx] = sum[9:0];
                     next_s.st[c] = acc_pkg::ACC_IDLE;
                  end else begin
                     next_s.acc[c] = sum;
                     next_s.left[c] = s.left[c] - `ACC_LEFT_ONE;
                     next_s.convert[c] = 1'b1;
                  end
               end
            end
         endcase
      end

      // register reads, answered one cycle later
      if (i_reg_rd) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = `ACC_RDATA_NONE;
         unique case (i_reg_addr)
            `ACC_ADDR_FS: begin
               next_s.rdata = {s.dac_fs, s.ref_en, s.ref_fs};
            end
            `ACC_ADDR_AVG_A, `ACC_ADDR_AVG_B: begin
               next_s.rdata = {5'h00, s.avg_code[i_reg_addr[0]]};
            end
            `ACC_ADDR_ADC_CTRL: begin
               // bits 4 and 3 read low, bit 3 being the B start bit
               next_s.rdata = {s.port_en, s.port_sel, s.ref_sel[1], 1'b0,
                               1'b0, s.ref_sel[0], s.input_sel,
                               1'b0};
            end
            `ACC_ADDR_CLK_DIV: begin
               next_s.rdata = {6'h00, s.clk_sel};
            end
            `ACC_ADDR_DAC_A, `ACC_ADDR_DAC_B, `ACC_ADDR_DAC_C: begin
               roff = i_reg_addr - `ACC_ADDR_DAC_A;
               next_s.rdata = s.dac_pend[roff[1:0]];
            end
            `ACC_ADDR_DAC_UPD: begin
               next_s.rdata = {s.slave_en, 7'h00};
            end
            `ACC_ADDR_DAC_PWR: begin
               next_s.rdata = {5'h00, s.dac_pwr};
            end
            default: begin
               if (i_reg_addr >= `ACC_ADDR_RES_FIRST &&
                   i_reg_addr <= `ACC_ADDR_RES_LAST) begin
                  roff = i_reg_addr - `ACC_ADDR_RES_FIRST;
                  // even offset upper eight bits, odd lower two
                  if (roff[2:1] == 2'h3) begin
                     next_s.rdata = `ACC_RDATA_NONE;
                  end else if (roff[0]) begin
                     next_s.rdata = {6'h00,
                                     s.result[roff[2:1]][1:0]};
                  end else begin
                     next_s.rdata = s.result[roff[2:1]][9:2];
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         s <= '0;
         // pin idles high; avoids a false edge after reset
         s.cs_q1 <= 1'b1;
         s.cs_q2 <= 1'b1;
         s.cs_q3 <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign o_reg_rdata = s.rdata;
   assign o_reg_rvalid = s.rvalid;
   assign o_adc_a_convert = s.convert[0];
   assign o_adc_b_convert = s.convert[1];
   assign o_adc_a_input_select = s.input_sel;
   assign o_adc_a_ref_internal = s.ref_sel[0];
   assign o_adc_b_ref_internal = s.ref_sel[1];
   assign o_aux_adc_clock_selection = s.clk_sel;
   assign o_ref_generator_enable = s.ref_en;
   // fullscale choice only matters with the generator on
   assign o_internal_reference_fullscale = s.ref_fs;
   assign o_aux_port_enable = s.port_en;
   assign o_aux_port_target_select = s.port_sel;
   assign o_dac_a_level = s.dac_live[0];
   assign o_dac_b_level = s.dac_live[1];
   assign o_dac_c_level = s.dac_live[2];
   assign o_dac_power_up = s.dac_pwr;
   assign o_dac_fullscale = s.dac_fs;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);

   a_avg_reads_zero: assert property (
      i_reg_rd && i_reg_addr == `ACC_ADDR_AVG_A |=> !o_reg_rdata[7])
      else $error("start-average bit read back high");

   a_start_reads_zero: assert property (
      i_reg_rd && i_reg_addr == `ACC_ADDR_ADC_CTRL
      |=> !o_reg_rdata[3] && !o_reg_rdata[0])
      else $error("start bit read back high");

   a_single_start_fires: assert property (
      i_reg_wr && i_reg_addr == `ACC_ADDR_ADC_CTRL && i_reg_wdata[0] &&
      s.st[0] == acc_pkg::ACC_IDLE |=> o_adc_a_convert ##1 !o_adc_a_convert)
      else $error("single start gave no one-cycle convert");

   a_port_gated_off: assert property (
      cs_fall && !s.port_en && s.st == '0 |=> !o_adc_a_convert &&
      !o_adc_b_convert)
      else $error("disabled aux port started a conversion");

   a_dac_immediate: assert property (
      i_reg_wr && i_reg_addr == `ACC_ADDR_DAC_A && !s.slave_en
      |=> o_dac_a_level == $past(i_reg_wdata))
      else $error("DAC A word not applied at once");

   a_dac_slave_hold: assert property (
      i_reg_wr && i_reg_addr == `ACC_ADDR_DAC_B && s.slave_en
      |=> o_dac_b_level == $past(o_dac_b_level))
      else $error("DAC B changed before its update");

   a_dac_update_apply: assert property (
      i_reg_wr && i_reg_addr == `ACC_ADDR_DAC_UPD && i_reg_wdata[7] &&
      i_reg_wdata[2] |=> o_dac_c_level == $past(s.dac_pend[2]))
      else $error("DAC C update did not apply pending word");

   a_dac_reset_zero: assert property (
      $past(i_srst) |-> o_dac_a_level == 8'h00 && o_dac_b_level == 8'h00 &&
      o_dac_c_level == 8'h00)
      else $error("DAC word not zero after reset");

   a_power_follows: assert property (
      i_reg_wr && i_reg_addr == `ACC_ADDR_DAC_PWR
      |=> o_dac_power_up == $past(i_reg_wdata[2:0]))
      else $error("DAC power bits did not follow the write");

   a_clock_select: assert property (
      i_reg_wr && i_reg_addr == `ACC_ADDR_CLK_DIV
      |=> o_aux_adc_clock_selection == $past(i_reg_wdata[1:0]))
      else $error("aux clock selection not taken");

   a_ctrl_read_map: assert property (
      i_reg_rd && i_reg_addr == `ACC_ADDR_ADC_CTRL
      |=> o_reg_rdata[7:5] == $past({o_aux_port_enable,
      o_aux_port_target_select, o_adc_b_ref_internal}) &&
      o_reg_rdata[2:1] == $past({o_adc_a_ref_internal,
      o_adc_a_input_select}))
      else $error("aux control read back in the wrong bit positions");

   a_result_low_pad: assert property (
      i_reg_rd && i_reg_addr >= `ACC_ADDR_RES_FIRST &&
      i_reg_addr <= `ACC_ADDR_RES_LAST && i_reg_addr[0]
      |=> o_reg_rdata[7:2] == 6'h00)
      else $error("result low byte carries more than two bits");

   c_single_b: cover property (
      i_reg_wr && i_reg_addr == `ACC_ADDR_ADC_CTRL && i_reg_wdata[3]);
   c_avg_done: cover property (
      s.st[0] == acc_pkg::ACC_SAMPLE && s.left[0] == 7'h04 ##[1:200]
      s.st[0] == acc_pkg::ACC_IDLE);
   c_pin_trigger: cover property (cs_fall && s.port_en && s.port_sel);
   c_slave_update: cover property (
      i_reg_wr && i_reg_addr == `ACC_ADDR_DAC_UPD && i_reg_wdata == 8'h87);

endmodule : acc_aux_converter_control

// file: logic/acc_params.svh
// register map, field positions and codes of the aux converter block
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ACC_ADDR_FS 8'h17
`define ACC_ADDR_AVG_A 8'h18
`define ACC_ADDR_AVG_B 8'h19
`define ACC_ADDR_RES_FIRST 8'h1a
`define ACC_ADDR_RES_LAST 8'h21
`define ACC_ADDR_ADC_CTRL 8'h22
`define ACC_ADDR_CLK_DIV 8'h23
`define ACC_ADDR_DAC_A 8'h24
`define ACC_ADDR_DAC_B 8'h25
`define ACC_ADDR_DAC_C 8'h26
`define ACC_ADDR_DAC_UPD 8'h28
`define ACC_ADDR_DAC_PWR 8'h29

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ACC_BIT_REF_EN 1
`define ACC_BIT_REF_FS 0
`define ACC_BIT_START_AVG 7
`define ACC_BIT_PORT_EN 7
`define ACC_BIT_PORT_SEL 6
`define ACC_BIT_REFSEL_B 5
`define ACC_BIT_START_B 3
`define ACC_BIT_REFSEL_A 2
`define ACC_BIT_INSEL_A 1
`define ACC_BIT_START_A 0
`define ACC_BIT_SLAVE_EN 7

// ----------------------------------------------------------------------
// codes and default values
// ----------------------------------------------------------------------
`define ACC_CODE_UNUSED 3'h7
`define ACC_CODE_MAX 3'h6
`define ACC_CODE_SINGLE 3'h0
`define ACC_LEFT_ONE 7'h01
`define ACC_RES_IDX_A2 2'h0
`define ACC_RES_IDX_A1 2'h1
`define ACC_RES_IDX_B 2'h2
`define ACC_RDATA_NONE 8'h00

`endif

// file: logic/acc_pkg.sv
// types shared by the aux converter control block
package acc_pkg;

   // per-ADC conversion sequencer
   typedef enum logic [0:0] {
      ACC_IDLE,
      ACC_SAMPLE
   } acc_adc_state_t;

   // the whole state of the block
   typedef struct packed {
      logic [5:0] dac_fs;
      logic ref_en;
      logic ref_fs;
      logic [1:0][2:0] avg_code;
      logic port_en;
      logic port_sel;
      logic [1:0] ref_sel;
      logic input_sel;
      logic [1:0] clk_sel;
      logic [2:0][7:0] dac_pend;
      logic [2:0][7:0] dac_live;
      logic slave_en;
      logic [2:0] dac_pwr;
      logic [2:0][9:0] result;
      acc_adc_state_t [1:0] st;
      logic [1:0][6:0] left;
      logic [1:0][15:0] acc;
      logic [1:0][2:0] shift;
      logic a_src;
      logic [1:0] convert;
      logic [7:0] rdata;
      logic rvalid;
      logic cs_q1;
      logic cs_q2;
      logic cs_q3;
   } acc_state_t;

endpackage : acc_pkg

// file: verif/acc_adc_model.sv
// behavioural aux SAR ADC answering the block's convert requests
`timescale 1ns/1ps

module acc_adc_model (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_srst,
   // conversion handshake
   input wire logic i_convert,
   input wire logic [3:0] i_delay,
   input wire logic [9:0] i_base,
   output logic o_done,
   output logic [9:0] o_data,
   // samples delivered so far
   output logic [15:0] o_count
);
   logic busy;
   logic [3:0] wait_left;
   logic [9:0] data_q;

   // ----------------------------------------------------------------
   // conversion timing
   // ----------------------------------------------------------------
   // ramping samples, so a wrong count or shift cannot hide
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         busy <= 1'b0;
         wait_left <= 4'h0;
         data_q <= 10'h000;
         o_done <= 1'b0;
         o_count <= 16'h0000;
      end else begin
         o_done <= 1'b0;
         if (i_convert) begin
            busy <= 1'b1;
            wait_left <= i_delay;
         end else if (busy) begin
            if (wait_left <= 4'h1) begin
               busy <= 1'b0;
               o_done <= 1'b1;
               data_q <= i_base + o_count[9:0];
               o_count <= o_count + 16'h0001;
            end else begin
               wait_left <= wait_left - 4'h1;
            end
         end
      end
   end

   // stale data is inverted so an early sample never matches by luck
   assign o_data = o_done ? data_q : ~data_q;
endmodule : acc_adc_model

// file: verif/tb_top.sv
// self-checking bench of the aux converter control block
`timescale 1ns/1ps

module tb_top;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic cs_n = 1'b1;
   logic [7:0] rdata;
   logic rvalid, a_conv, a_done, a_insel, a_ref, b_conv, b_done, b_ref;
   logic [9:0] a_data, b_data;
   logic [1:0] clk_sel;
   logic ref_gen, ref_fs, port_en, port_tgt;
   logic [7:0] lv_a, lv_b, lv_c;
   logic [2:0] pwr;
   logic [5:0] dfs;
   logic [15:0] a_cnt, b_cnt;
   int fails = 0;
   int checks_done = 0;
   int cycles = 0;
   localparam logic [9:0] BASE_A = 10'h3f0;
   localparam logic [9:0] BASE_B = 10'h155;

   // ----------------------------------------------------------------
   // design and far-side converters
   // ----------------------------------------------------------------
   acc_aux_converter_control dut (.i_mclk(mclk), .i_srst(srst),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
      .i_aux_cs_n(cs_n), .o_adc_a_convert(a_conv),
      .i_adc_a_done(a_done), .i_adc_a_data(a_data),
      .o_adc_a_input_select(a_insel), .o_adc_a_ref_internal(a_ref),
      .o_adc_b_convert(b_conv), .i_adc_b_done(b_done),
      .i_adc_b_data(b_data), .o_adc_b_ref_internal(b_ref),
      .o_aux_adc_clock_selection(clk_sel),
      .o_ref_generator_enable(ref_gen),
      .o_internal_reference_fullscale(ref_fs),
      .o_aux_port_enable(port_en), .o_aux_port_target_select(port_tgt),
      .o_dac_a_level(lv_a), .o_dac_b_level(lv_b), .o_dac_c_level(lv_c),
      .o_dac_power_up(pwr), .o_dac_fullscale(dfs));
   // a answers promptly, b slowly
   acc_adc_model adc_a (.i_mclk(mclk), .i_srst(srst), .i_convert(a_conv),
      .i_delay(4'h1), .i_base(BASE_A), .o_done(a_done), .o_data(a_data),
      .o_count(a_cnt));
   acc_adc_model adc_b (.i_mclk(mclk), .i_srst(srst), .i_convert(b_conv),
      .i_delay(4'h5), .i_base(BASE_B), .o_done(b_done), .o_data(b_data),
      .o_count(b_cnt));

   // ----------------------------------------------------------------
   // clock, timeout and shared tasks
   // ----------------------------------------------------------------
   always #5 mclk = ~mclk;
   // whole run needs a few thousand cycles at most
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string nm, input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_rd = 1'b1;
      addr = a;
      @(negedge mclk);
      reg_rd = 1'b0;
      // rvalid stands for one cycle only, so look at it now
      chk("rvalid", 16'(rvalid), 16'h1);
      d = rdata;
   endtask : rd

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk($sformatf("reg %h", a), 16'(d), 16'(e));
   endtask : rdchk

   function automatic logic [9:0] avg(input logic [9:0] base,
                                      input int st, input int code);
      logic [15:0] s;
      s = 16'h0000;
      for (int k = 0; k < (1 << code); k++) s = s + 16'(10'(base + st + k));
      return 10'(s >> code);
   endfunction : avg

   // bounded wait for the model's sample count, then result settles
   task automatic wait_samples(input bit b, input int target);
      for (int i = 0; i < 2000; i++) begin
         if ((b ? b_cnt : a_cnt) == 16'(target)) break;
         @(negedge mclk);
      end
      repeat (3) @(negedge mclk);
      chk("samples", b ? b_cnt : a_cnt, 16'(target));
   endtask : wait_samples

   task automatic chk_result(input logic [7:0] slot, input logic [9:0] e);
      rdchk(slot, e[9:2]);
      rdchk(slot + 8'h01, {6'h00, e[1:0]});
   endtask : chk_result

   task automatic conv_avg(input bit b, input int code, logic [7:0] slot);
      int st;
      logic [7:0] d;
      st = b ? b_cnt : a_cnt;
      wr(b ? 8'h19 : 8'h18, 8'h80 | 8'(code));
      wait_samples(b, st + (1 << code));
      chk_result(slot, avg(b ? BASE_B : BASE_A, st, code));
      rd(b ? 8'h19 : 8'h18, d);
      chk("avg start", 16'(d[7]), 16'h0);
   endtask : conv_avg

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_dac();
      chk("dac a", 16'(lv_a), 16'h0);
      rdchk(8'h26, 8'h00);
      wr(8'h24, 8'h55);
      chk("dac a", 16'(lv_a), 16'h55);
      wr(8'h25, 8'haa);
      wr(8'h26, 8'hff);
      chk("dac c", 16'(lv_c), 16'hff);
      wr(8'h28, 8'h80);
      wr(8'h24, 8'h12);
      wr(8'h25, 8'h34);
      wr(8'h26, 8'h56);
      chk("dac a held", 16'(lv_a), 16'h55);
      wr(8'h28, 8'h81);
      chk("dac a upd", 16'(lv_a), 16'h12);
      chk("dac b held", 16'(lv_b), 16'haa);
      rdchk(8'h28, 8'h80);
      wr(8'h28, 8'h86);
      chk("dac b upd", 16'(lv_b), 16'h34);
      chk("dac c upd", 16'(lv_c), 16'h56);
      wr(8'h28, 8'h00);
      chk("dac power", 16'(pwr), 16'h0);
      for (int i = 0; i < 8; i++) begin
         wr(8'h29, 8'(i));
         chk("dac power", 16'(pwr), 16'(i));
      end
   endtask : t_dac

   task automatic t_settings();
      wr(8'h17, 8'hb6);
      chk("dac fs", 16'(dfs), 16'h2d);
      chk("ref fs", 16'({ref_gen, ref_fs}), 16'h2);
      wr(8'h17, 8'h4b);
      chk("dac fs", 16'(dfs), 16'h12);
      chk("ref fs", 16'({ref_gen, ref_fs}), 16'h3);
      wr(8'h22, 8'h66);
      chk("port", 16'({port_en, port_tgt}), 16'h1);
      chk("refsel", 16'({b_ref, a_ref}), 16'h3);
      chk("insel", 16'(a_insel), 16'h1);
      rdchk(8'h22, 8'h66);
      wr(8'h22, 8'h80);
      chk("port", 16'({port_en, port_tgt}), 16'h2);
      rdchk(8'h22, 8'h80);
      wr(8'h18, 8'h07);
      rdchk(8'h18, 8'h06);
      chk("refsel", 16'({b_ref, a_ref, a_insel}), 16'h0);
      for (int i = 0; i < 4; i++) begin
         wr(8'h23, 8'(i));
         chk("clk sel", 16'(clk_sel), 16'(i));
      end
      // leave the slowest rx-derived rate selected for the conversions
      wr(8'h23, 8'h00);
      chk("clk sel", 16'(clk_sel), 16'h0);
   endtask : t_settings

   task automatic t_convert();
      int n;
      logic [7:0] d;
      n = a_cnt;
      wr(8'h22, 8'h01);
      wait_samples(0, n + 1);
      chk_result(8'h1a, 10'(BASE_A + n));
      rdchk(8'h22, 8'h00);
      n = b_cnt;
      wr(8'h22, 8'h08);
      wait_samples(1, n + 1);
      chk_result(8'h1e, 10'(BASE_B + n));
      for (int c = 0; c < 7; c++) conv_avg(1, c, 8'h1e);
      wr(8'h22, 8'h02);
      conv_avg(0, 3, 8'h1c);
      rd(8'h1c, d);
      wr(8'h1c, ~d);
      rdchk(8'h1c, d);
      rdchk(8'h20, 8'h00);
      rdchk(8'h30, 8'h00);
   endtask : t_convert

   task automatic pulse_cs();
      @(negedge mclk);
      cs_n = 1'b0;
      repeat (4) @(negedge mclk);
      cs_n = 1'b1;
      @(negedge mclk);
   endtask : pulse_cs

   task automatic t_cs();
      int n;
      int m;
      wr(8'h19, 8'h01);
      wr(8'h22, 8'hc0);
      n = b_cnt;
      m = a_cnt;
      pulse_cs();
      wait_samples(1, n + 2);
      chk_result(8'h1e, avg(BASE_B, n, 1));
      chk("a idle", a_cnt, 16'(m));
      wr(8'h22, 8'h40);
      pulse_cs();
      repeat (20) @(negedge mclk);
      chk("port off", b_cnt, 16'(n + 2));
   endtask : t_cs

   initial begin
      repeat (12) @(negedge mclk);
      srst = 1'b0;
      t_dac();
      t_settings();
      t_convert();
      t_cs();
      report_and_stop();
   end
endmodule : tb_top
